// file: core/ies_entry.sv
// interruption delivery, vector dispatch and return sequencing
// What this block does
// - control writes wait for serialization: explicit, delivery or return
// - delivery serializes all but two exempt resources
// - return serializes instruction and data streams
// - return writes win over earlier writes
// - lightweight entries are 1024 bytes, 192 instructions
// - heavyweight entries are 256 bytes, 48 instructions
// - first twenty vectors are lightweight, miss at 0x800
// - collection off or in-flight means nested
// - delivery selects bank 0, clears both enables
// - return restores status and resumes at saved pointer
// - delivery records interrupted slot number
// - nested delivery updates only status info, sets nested
`timescale 1ns/10ps
`include "ies_defs.svh"
module ies_entry #(
  parameter int W = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] psr_in,
  input wire logic [W-1:0] ip_in,
  input wire logic [`IES_SLOT_W-1:0] slot_in,
  input wire logic [W-1:0] isr_in,
  input wire logic intr_req,
  input wire logic [`IES_VEC_W-1:0] intr_vector,
  input wire logic intr_data_nested,
  input wire logic rfi_req,
  input wire logic srlz_req,
  input wire logic base_wr,
  input wire logic [W-1:0] base_wr_data,
  input wire logic ctl_wr,
  input wire logic [W-1:0] ctl_wr_data,
  input wire logic coll_wr,
  input wire logic coll_wr_val,
  input wire logic iip_wr,
  input wire logic [W-1:0] iip_wr_data,
  input wire logic saved_status_copy_wr,
  input wire logic [W-1:0] saved_status_copy_wr_data,
  input wire logic handler_byte_order,
  input wire logic handler_priv_monitoring,
  output logic [W-1:0] psr_out,
  output logic [W-1:0] fetch_addr,
  output logic fetch_valid,
  output logic [W-1:0] saved_instruction_pointer,
  output logic [W-1:0] saved_status_copy,
  output logic [W-1:0] interruption_status_info,
  output logic nested_taken,
  output logic lightweight_entry,
  output logic [W-1:0] ctl_live,
  output logic ctl_pending,
  output logic collection_enable,
  output logic collection_pending,
  output logic [W-1:0] vector_table_base
);
  import ies_pkg::*;
  ies_cr_if #(.W(W)) ctl_cr();
  ies_state_t state_r;
  logic coll_r;
  logic coll_held_r;
  logic coll_pend_r;
  logic [W-1:0] base_r;
  logic [W-1:0] ctl_out_r;
  logic ctl_pend_out_r;
  logic deliver;
  logic nested;
  logic [15:0] vec_ofs;
  logic is_lw;

  ies_cr_slot #(.W(W)) u_ctl (.clk(clk), .rst_b(rst_b), .cr(ctl_cr));
  assign ctl_cr.wr_en = ctl_wr;
  assign ctl_cr.wr_data = ctl_wr_data;
  // both delivery and return flush the non-exempt pending state
  assign ctl_cr.srlz = srlz_req || deliver || rfi_req;
  assign deliver = intr_req && state_r == ies_st_idle;
  assign nested = !coll_r || coll_pend_r;

  // lightweight vectors step 1024 bytes, heavyweight 256 past the boundary
  always_comb begin
    is_lw = 32'(intr_vector) < `IES_LW_COUNT;
    if (is_lw) begin
      vec_ofs = 16'(32'(intr_vector) * `IES_LW_ENTRY_BYTES);
    end else begin
      vec_ofs = 16'(`IES_HW_BASE_OFS + (32'(intr_vector) - `IES_LW_COUNT) * `IES_HW_ENTRY_BYTES);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ies_st_idle;
    end else if (deliver) begin
      state_r <= ies_st_deliver;
    end else if (!intr_req) begin
      state_r <= ies_st_idle;
    end
  end

  // exempt: delivery drops an in-flight collection enable write and clears the enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coll_r <= 1'b0;
      coll_held_r <= 1'b0;
      coll_pend_r <= 1'b0;
    end else if (deliver) begin
      coll_r <= 1'b0;
      coll_pend_r <= 1'b0;
    end else if (rfi_req) begin
      coll_r <= saved_status_copy[`IES_COLLECTION_ENABLE];
      coll_pend_r <= 1'b0;
    end else if (coll_wr && coll_wr_val != (coll_pend_r ? coll_held_r : coll_r)) begin
      coll_held_r <= coll_wr_val;
      coll_pend_r <= 1'b1;
    end else if (srlz_req && coll_pend_r) begin
      coll_r <= coll_held_r;
      coll_pend_r <= 1'b0;
    end
  end

  // exempt: base change is not flushed by delivery; software guards it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_r <= '0;
    end else if (base_wr) begin
      base_r <= base_wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      saved_instruction_pointer <= '0;
      saved_status_copy <= '0;
    end else if (deliver && !nested) begin
      saved_instruction_pointer <= ip_in;
      saved_status_copy <= psr_in;
      saved_status_copy[`IES_SLOT_W-1:0] <= (slot_in > `IES_SLOT_MAX) ? `IES_SLOT_MAX : slot_in;
    end else begin
      if (iip_wr) begin
        saved_instruction_pointer <= iip_wr_data;
      end
      if (saved_status_copy_wr) begin
        saved_status_copy <= saved_status_copy_wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interruption_status_info <= '0;
      nested_taken <= 1'b0;
    end else if (deliver) begin
      interruption_status_info <= isr_in;
      interruption_status_info[`IES_NESTED_INDICATOR] <= nested && !intr_data_nested;
      nested_taken <= nested;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psr_out <= '0;
      fetch_addr <= '0;
      fetch_valid <= 1'b0;
      lightweight_entry <= 1'b0;
    end else if (deliver) begin
      psr_out <= psr_in;
      psr_out[`IES_COLLECTION_ENABLE] <= 1'b0;
      psr_out[`IES_EXTERNAL_INTERRUPT_ENABLE] <= 1'b0;
      psr_out[`IES_PSR_BN] <= 1'b0;
      psr_out[`IES_SLOT_W-1:0] <= '0;
      psr_out[`IES_PSR_BE] <= handler_byte_order;
      psr_out[`IES_PSR_PP] <= handler_priv_monitoring;
      fetch_addr <= base_r + W'(vec_ofs);
      fetch_valid <= 1'b1;
      lightweight_entry <= is_lw;
    end else if (rfi_req) begin
      psr_out <= saved_status_copy;
      fetch_addr <= saved_instruction_pointer;
      fetch_valid <= 1'b1;
    end else begin
      fetch_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_out_r <= '0;
      ctl_pend_out_r <= 1'b0;
    end else begin
      ctl_out_r <= ctl_cr.live;
      ctl_pend_out_r <= ctl_cr.pending;
    end
  end
  assign ctl_live = ctl_out_r;
  assign ctl_pending = ctl_pend_out_r;
  assign collection_enable = coll_r;
  assign collection_pending = coll_pend_r;
  assign vector_table_base = base_r;

  a_entry_clears: assert property (@(posedge clk) disable iff (!rst_b)
    deliver |=> !psr_out[`IES_COLLECTION_ENABLE] && !psr_out[`IES_EXTERNAL_INTERRUPT_ENABLE] && !psr_out[`IES_PSR_BN] && fetch_valid)
    else $error("delivery left an enable or bank set");
  a_fetch_addr: assert property (@(posedge clk) disable iff (!rst_b)
    deliver |=> fetch_addr == $past(base_r) + W'($past(vec_ofs))) else $error("bad vector fetch address");
  a_lw_size: assert property (@(posedge clk) disable iff (!rst_b)
    (intr_vector == 7'h02) |-> vec_ofs == `IES_DTLB_OFS) else $error("miss vector not at 0x800");
  a_hw_size: assert property (@(posedge clk) disable iff (!rst_b)
    (intr_vector == 7'h15) |-> vec_ofs == `IES_HW_BASE_OFS + `IES_HW_ENTRY_BYTES) else $error("heavy entry size");
  a_nested_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (deliver && nested) |=> $stable(saved_instruction_pointer) && $stable(saved_status_copy))
    else $error("nested delivery overwrote saved state");
  a_nested_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (deliver && nested && !intr_data_nested) |=> interruption_status_info[`IES_NESTED_INDICATOR])
    else $error("nested indicator not set");
  a_rfi_restore: assert property (@(posedge clk) disable iff (!rst_b)
    (rfi_req && !deliver) |=> psr_out == $past(saved_status_copy) && fetch_addr == $past(saved_instruction_pointer))
    else $error("return did not restore state");
  a_rfi_flush: assert property (@(posedge clk) disable iff (!rst_b)
    (rfi_req && !ctl_wr) |=> !ctl_cr.pending) else $error("return left control write in-flight");
  a_deliver_flush: assert property (@(posedge clk) disable iff (!rst_b)
    (deliver && !ctl_wr) |=> ##1 !ctl_pending) else $error("delivery left control write in-flight");
  a_slot_saved: assert property (@(posedge clk) disable iff (!rst_b)
    (deliver && !nested && slot_in <= `IES_SLOT_MAX) |=> saved_status_copy[`IES_SLOT_W-1:0] == $past(slot_in))
    else $error("slot number not recorded");
endmodule

// file: core/ies_defs.svh
// constants for the interruption entry and serialization block
`ifndef IES_DEFS_SVH
`define IES_DEFS_SVH
`define IES_LW_ENTRY_BYTES 1024
`define IES_LW_ENTRY_INSNS 192
`define IES_HW_ENTRY_BYTES 256
`define IES_HW_ENTRY_INSNS 48
`define IES_LW_COUNT 20
`define IES_LW_LAST_OFS 16'h4c00
`define IES_HW_BASE_OFS 16'h5000
`define IES_DTLB_OFS 16'h0800
`define IES_VEC_W 7
`define IES_SLOT_W 2
`define IES_SLOT_MAX 2'h2
`define IES_COLLECTION_ENABLE 13
`define IES_EXTERNAL_INTERRUPT_ENABLE 14
`define IES_PSR_BN 44
`define IES_PSR_BE 2
`define IES_PSR_PP 3
`define IES_NESTED_INDICATOR 39
`endif

// file: core/ies_pkg.sv
// types for the interruption entry and serialization block
package ies_pkg;
  typedef enum logic [1:0] {
    ies_kind_lightweight_t_ok,
    ies_kind_heavyweight,
    ies_kind_none
  } ies_kind_t;
  typedef enum logic {
    ies_st_idle,
    ies_st_deliver
  } ies_state_t;
endpackage

// file: core/ies_cr_if.sv
// pending and live control register pair carried between modules
`timescale 1ns/10ps
interface ies_cr_if #(parameter int W = 64);
  logic [W-1:0] live;
  logic pending;
  logic wr_en;
  logic [W-1:0] wr_data;
  logic srlz;
  modport owner(input wr_en, input wr_data, input srlz, output live, output pending);
  modport user(output wr_en, output wr_data, output srlz, input live, input pending);
endinterface

// file: core/ies_cr_slot.sv
// one control register with in-flight hold until serialized
`timescale 1ns/10ps
module ies_cr_slot #(
  parameter int W = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  ies_cr_if.owner cr
);
  logic [W-1:0] live_r;
  logic [W-1:0] held_r;
  logic pending_r;
  assign cr.live = live_r;
  assign cr.pending = pending_r;
  // a write of the same value is not in-flight
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      held_r <= '0;
      pending_r <= 1'b0;
    end else if (cr.wr_en && cr.wr_data != (pending_r ? held_r : live_r)) begin
      held_r <= cr.wr_data;
      pending_r <= 1'b1;
    end else if (cr.srlz) begin
      pending_r <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      live_r <= '0;
    end else if (cr.srlz && pending_r) begin
      live_r <= held_r;
    end
  end
  a_inflight_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (pending_r && !cr.srlz) |=> $stable(live_r)) else $error("in-flight value took effect early");
endmodule

// file: tb/ies_os_model.sv
// handler software model: rewrites saved state to skip an instruction, then returns
`timescale 1ns/10ps
module ies_os_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [63:0] skip_ip,
  input wire logic [63:0] saved_instruction_pointer,
  input wire logic [63:0] saved_status_copy,
  input wire logic [63:0] interruption_status_info,
  input wire logic [63:0] entry_addr,
  input wire logic [63:0] table_base,
  output logic iip_wr,
  output logic [63:0] iip_wr_data,
  output logic saved_status_copy_wr,
  output logic [63:0] saved_status_copy_wr_data,
  output logic rfi_req
);
  // model-side assumptions, values arbitrary
  localparam int CPL_LO = 32;
  localparam int STACKED_REGS = 96;
  localparam logic SP_ON_KERNEL = 1'b0;
  localparam logic [63:0] KERNEL_BS_BASE = 64'h0080_0000;
  logic [63:0] stub_copy [4];
  logic [63:0] trap_frame_status;
  logic [63:0] bs_write_ptr;
  logic stack_switched;
  // worst-case spill area unless the stacked count is known
  function automatic logic [63:0] min_bs_ofs(input int n);
    if (n <= 0) return 64'h4000;
    return 64'(8 * (n + 1 + (n + 62) / 63));
  endfunction
  // never touches the exempt resources, so no masking window is needed
  always @(posedge clk) begin
    if (go) begin
      stub_copy[0] <= saved_instruction_pointer;
      stub_copy[1] <= saved_status_copy;
      stub_copy[2] <= interruption_status_info;
      stub_copy[3] <= entry_addr - table_base;
      stack_switched <= !(saved_status_copy[CPL_LO +: 2] == 2'h0 && SP_ON_KERNEL);
      bs_write_ptr <= KERNEL_BS_BASE + min_bs_ofs(STACKED_REGS);
      trap_frame_status <= saved_status_copy;
    end
    iip_wr <= go;
    saved_status_copy_wr <= go;
    iip_wr_data <= skip_ip;
    saved_status_copy_wr_data <= {saved_status_copy[63:2], 2'h1};
    // return only once saved state is rewritten
    rfi_req <= iip_wr;
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for interruption delivery, dispatch and return
`timescale 1ns/10ps
module testbench;
  localparam logic [63:0] BASE = 64'h0001_0000;
  localparam logic [63:0] PSR = 64'h0000_1000_0000_6000;
  localparam logic [63:0] IP = 64'h4000_0100;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [63:0] psr_in, ip_in, isr_in, base_wr_data, ctl_wr_data, skip_ip;
  logic [1:0] slot_in;
  logic [6:0] intr_vector;
  logic intr_req, intr_data_nested, srlz_req, base_wr, ctl_wr, coll_wr, coll_wr_val, go, hbo, hpm;
  logic rfi_req, iip_wr, saved_status_copy_wr;
  logic [63:0] iip_wr_data, saved_status_copy_wr_data, psr_out, fetch_addr, sip, ssc, isi, ctl_live, vtb;
  logic fetch_valid, nested_taken, lightweight_entry, ctl_pending, coll_en, coll_pend;
  int fails = 0;
  int n_tests = 0;
  int vs[5] = '{0, 19, 20, 21, 63};
  always #2 clk = ~clk;
  ies_entry DUT (.clk(clk), .rst_b(rst_b), .psr_in(psr_in), .ip_in(ip_in), .slot_in(slot_in),
    .isr_in(isr_in), .intr_req(intr_req), .intr_vector(intr_vector), .intr_data_nested(intr_data_nested),
    .rfi_req(rfi_req), .srlz_req(srlz_req), .base_wr(base_wr), .base_wr_data(base_wr_data),
    .ctl_wr(ctl_wr), .ctl_wr_data(ctl_wr_data), .coll_wr(coll_wr), .coll_wr_val(coll_wr_val),
    .iip_wr(iip_wr), .iip_wr_data(iip_wr_data), .saved_status_copy_wr(saved_status_copy_wr), .saved_status_copy_wr_data(saved_status_copy_wr_data),
    .handler_byte_order(hbo), .handler_priv_monitoring(hpm), .psr_out(psr_out), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .saved_instruction_pointer(sip), .saved_status_copy(ssc),
    .interruption_status_info(isi), .nested_taken(nested_taken), .lightweight_entry(lightweight_entry),
    .ctl_live(ctl_live), .ctl_pending(ctl_pending), .collection_enable(coll_en),
    .collection_pending(coll_pend), .vector_table_base(vtb));
  ies_os_model os (.clk(clk), .go(go), .skip_ip(skip_ip), .saved_instruction_pointer(sip),
    .saved_status_copy(ssc), .interruption_status_info(isi), .entry_addr(fetch_addr), .table_base(vtb),
    .iip_wr(iip_wr), .iip_wr_data(iip_wr_data), .saved_status_copy_wr(saved_status_copy_wr), .saved_status_copy_wr_data(saved_status_copy_wr_data),
    .rfi_req(rfi_req));
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // lightweight slots first, heavyweight slots packed after them
  function automatic logic [63:0] exp_addr(input int v);
    return BASE + ((v < 20) ? v * 1024 : 64'h5000 + (v - 20) * 256);
  endfunction
  task deliver(input int v);
    @(posedge clk) intr_req <= 1'b1;
    intr_vector <= v[6:0];
    @(posedge clk) intr_req <= 1'b0;
    #1 chk("fetch_valid", fetch_valid, 64'h1);
    chk("fetch_addr", fetch_addr, exp_addr(v));
    chk("lightweight", lightweight_entry, (v < 20) ? 64'h1 : 64'h0);
    wait_n(1);
    chk("fetch_pulse", fetch_valid, 64'h0);
  endtask
  initial begin
    {intr_req, intr_data_nested, srlz_req, base_wr, ctl_wr, coll_wr, coll_wr_val, go, hpm} = '0;
    hbo = 1'b1;
    psr_in = PSR;
    ip_in = IP;
    isr_in = 64'habc;
    slot_in = 2'h2;
    intr_vector = 7'h0;
    {base_wr_data, ctl_wr_data} = '0;
    skip_ip = IP + 64'h10;
    wait_n(4);
    rst_b <= 1'b1;
    @(posedge clk) {base_wr, coll_wr, coll_wr_val, ctl_wr} <= 4'hf;
    base_wr_data <= BASE;
    ctl_wr_data <= 64'h55;
    @(posedge clk) {base_wr, coll_wr, ctl_wr} <= 3'h0;
    wait_n(1);
    chk("base", vtb, BASE);
    chk("ctl_pending", ctl_pending, 64'h1);
    chk("ctl_held", ctl_live, 64'h0);
    chk("coll_held", coll_en, 64'h0);
    chk("coll_pend", coll_pend, 64'h1);
    @(posedge clk) srlz_req <= 1'b1;
    @(posedge clk) srlz_req <= 1'b0;
    wait_n(1);
    chk("ctl_live", ctl_live, 64'h55);
    chk("coll_en", coll_en, 64'h1);
    chk("coll_pend_done", coll_pend, 64'h0);
    @(posedge clk) ctl_wr <= 1'b1;
    ctl_wr_data <= 64'haa;
    @(posedge clk) ctl_wr <= 1'b0;
    deliver(2);
    chk("ctl_flush_pend", ctl_pending, 64'h0);
    chk("ctl_flush", ctl_live, 64'haa);
    chk("coll_cleared", coll_en, 64'h0);
    chk("psr_env", {psr_out[44], psr_out[14], psr_out[13], psr_out[3], psr_out[2]}, 64'h1);
    chk("slot", ssc, {PSR[63:2], 2'h2});
    chk("saved_ip", sip, IP);
    chk("not_nested", nested_taken, 64'h0);
    chk("isi_plain", isi, 64'habc);
    @(posedge clk) ctl_wr <= 1'b1;
    ctl_wr_data <= 64'h77;
    go <= 1'b1;
    @(posedge clk) {ctl_wr, go} <= 2'h0;
    for (int i = 0; i < 8 && fetch_valid !== 1'b1; i++) wait_n(1);
    chk("rfi_ip", fetch_addr, IP + 64'h10);
    chk("rfi_psr", psr_out, {PSR[63:2], 2'h1});
    wait_n(1);
    chk("stub_ip", os.stub_copy[0], IP);
    chk("stub_vec_ofs", os.stub_copy[3], 64'h800);
    chk("rfi_coll", coll_en, 64'h1);
    chk("rfi_srlz_pend", ctl_pending, 64'h0);
    chk("rfi_srlz", ctl_live, 64'h77);
    @(posedge clk) coll_wr <= 1'b1;
    coll_wr_val <= 1'b0;
    ip_in <= 64'h9990;
    @(posedge clk) coll_wr <= 1'b0;
    deliver(3);
    chk("nested", nested_taken, 64'h1);
    chk("ni_bit", isi, 64'h0000_0080_0000_0abc);
    chk("sip_kept", sip, IP + 64'h10);
    foreach (vs[i]) deliver(vs[i]);
    @(posedge clk) intr_data_nested <= 1'b1;
    deliver(4);
    chk("data_nested_ni", isi, 64'habc);
    chk("data_nested", nested_taken, 64'h1);
    @(posedge clk) {rst_b, intr_data_nested} <= 2'h0;
    wait_n(1);
    chk("rst_coll", coll_en, 64'h0);
    chk("rst_base", vtb, 64'h0);
    @(posedge clk) rst_b <= 1'b1;
    @(posedge clk) base_wr <= 1'b1;
    @(posedge clk) base_wr <= 1'b0;
    deliver(1);
    chk("rst_nested", nested_taken, 64'h1);
    chk("rst_ni_bit", isi, 64'h0000_0080_0000_0abc);
    stop_test;
  end
  initial begin
    #4000;
    fails++;
    stop_test;
  end
endmodule
